// ===== verilog/uart_cfg.svh
// Register map, field positions, reset values and bit counts
`ifndef UART_CFG_SVH
`define UART_CFG_SVH

// ********************************
// Register offsets
// ********************************
`define OFF_CTRL1      3'h2
`define OFF_CTRL2      3'h3
`define OFF_STAT1      3'h4
`define OFF_CTRL3      3'h6
`define OFF_DATA       3'h7

// ********************************
// Control register 1 fields
// ********************************
`define C1_LOOPBACK    7
`define C1_RX_SOURCE   5
`define C1_WAKE_SEL    3

// ********************************
// Control register 2 fields
// ********************************
`define C2_TX_EMPTY_IE 7
`define C2_TX_DONE_IE  6
`define C2_RX_FULL_IE  5
`define C2_QUIET_IE    4
`define C2_TX_ON       3
`define C2_RX_ON       2
`define C2_STANDBY     1
`define C2_BREAK       0

// ********************************
// Control register 3 fields
// ********************************
`define C3_LONG_BREAK  7
`define C3_LINE_DIR    5

// ********************************
// Status register 1 fields
// ********************************
`define S1_TX_EMPTY    7
`define S1_TX_DONE     6
`define S1_RX_FULL     5
`define S1_QUIET       4
`define S1_OVERRUN     3

// ********************************
// Reset values and bit counts
// ********************************
`define CTRL_RESET     8'h00
`define CHAR_BITS      4'hA
`define BREAK_BITS     4'hA
`define LONG_BRK_BITS  4'hD
`define IDLE_BITS      10

`endif

// ===== verilog/uart_pkg.sv
// Shared types of the serial control and status block
package uart_pkg;

  typedef enum logic [1:0] {
    FRAME_DATA  = 2'h0,
    FRAME_IDLE  = 2'h1,
    FRAME_BREAK = 2'h2
  } frame_kind_t;

  typedef enum logic [1:0] {
    RX_WAIT  = 2'h0,
    RX_START = 2'h1,
    RX_DATA  = 2'h3,
    RX_STOP  = 2'h2
  } rx_state_t;

endpackage

// ===== verilog/tx_serializer.sv
// Transmit shifter for data, idle and break characters
`timescale 1ns/10ps
`include "uart_cfg.svh"
module tx_serializer #(
  parameter int unsigned BIT_CLKS = 16
) (
  input  wire logic                 core_clk,
  input  wire logic                 nrst,
  input  wire logic                 start,
  input  wire uart_pkg::frame_kind_t kind,
  input  wire logic [7:0]           data,
  input  wire logic                 long_break,
  output logic                      busy,
  output logic                      done,
  output logic                      tx_bit
);
  import uart_pkg::*;

  logic        busy_q;
  logic [15:0] cnt_q;
  logic [3:0]  left_q;
  logic [13:0] shift_q;
  logic [13:0] load;
  logic [3:0]  load_len;
  logic        bit_end;

  assign bit_end = (cnt_q == 16'(BIT_CLKS - 1));
  assign busy    = busy_q;
  assign done    = busy_q && bit_end && (left_q == 4'h1);

  always_comb begin
    load     = 14'h3FFF;
    load_len = `CHAR_BITS;
    unique case (kind)
      FRAME_DATA: begin
        load = {5'h1F, data, 1'b0};
      end
      FRAME_IDLE: begin
        load = 14'h3FFF;
      end
      FRAME_BREAK: begin
        load     = 14'h0000;
        load_len = long_break ? `LONG_BRK_BITS : `BREAK_BITS;
      end
      default: begin
        load = 14'h3FFF;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      busy_q  <= 1'b0;
      cnt_q   <= 16'h0000;
      left_q  <= 4'h0;
      shift_q <= 14'h3FFF;
      tx_bit  <= 1'b1;
    end else if (start && !busy_q) begin
      busy_q  <= 1'b1;
      cnt_q   <= 16'h0000;
      left_q  <= load_len;
      tx_bit  <= load[0];
      shift_q <= {1'b1, load[13:1]};
    end else if (busy_q) begin
      if (bit_end) begin
        cnt_q <= 16'h0000;
        if (left_q == 4'h1) begin
          busy_q <= 1'b0;
          tx_bit <= 1'b1;
        end else begin
          left_q  <= left_q - 4'h1;
          tx_bit  <= shift_q[0];
          shift_q <= {1'b1, shift_q[13:1]};
        end
      end else begin
        cnt_q <= cnt_q + 16'h0001;
      end
    end
  end

endmodule // tx_serializer

// ===== verilog/uart_control_and_status.sv
// Serial port control register, status register and pin control
//
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/10ps
`include "uart_cfg.svh"
// ********************************
// How it works
// - Transmit-empty flag raises interrupt when its enable bit 7 is set.
// - Transmit-done flag raises interrupt when its enable bit 6 is set.
// - Receive-full flag raises interrupt when its enable bit 5 is set.
// - Line-quiet flag raises interrupt when its enable bit 4 is set.
// - Transmitter runs with bit 3 set or while it still owns the pin; bit 3 set gives it the pin.
// - Single-wire mode uses direction bit to drive or listen on pin.
// - Turning transmitter off then on queues one idle character.
// - Pin stays owned until pending data, idle or break are sent.
// - Receive pin released when receiver off or loopback selected.
// - Software sets standby; hardware clears it on wakeup condition.
// - Wake on quiet line, or on character with top bit one.
// - Writing break bit one then zero queues one break character.
// - Holding break bit keeps queuing breaks of 10 or 13 bits.
// - A second break may be queued before software clears the bit.
// - Control register readable and writable at any time.
// - Status register has five read-only flags; writes do nothing.
// - Flags other than transmit-done clear only by status read then data access.
// - Loopback feeds transmitter into receiver; source picks pin use.
// - Status read then data write clears transmit-empty flag.
// - Transmit-done clears by data write, transmitter enable, break.
// ********************************
module uart_control_and_status #(
  parameter int unsigned BIT_CLKS = 16
) (
  input  wire logic       core_clk,
  input  wire logic       nrst,
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic [7:0]      reg_rdata,
  input  wire logic       tx_pin_in,
  output logic            tx_pin_out,
  output logic            tx_pin_oe,
  input  wire logic       rx_pin_in,
  output logic            rx_pin_owned,
  output logic            tx_pin_owned,
  output logic            irq_req
);
  import uart_pkg::*;

  localparam int unsigned IDLE_CLKS = `IDLE_BITS * BIT_CLKS;
  localparam int unsigned HALF_CLKS = BIT_CLKS / 2;

  function automatic logic hit(input logic [2:0] a,
                               input logic [2:0] off);
    hit = (a == off);
  endfunction

  // ********************************
  // Register state
  // ********************************
  logic [7:0]  ctrl1_q;
  logic [7:0]  ctrl2_q;
  logic [7:0]  ctrl3_q;
  logic [7:0]  tx_buf_q;
  logic [7:0]  rx_data_q;
  logic        tx_buffer_empty_flag_q;
  logic        rx_buffer_full_flag_q;
  logic        quiet_q;
  logic        ovr_q;
  logic [4:0]  arm_q;
  logic        idle_pend_q;
  logic        brk_pend_q;
  logic        owned_q;
  logic [1:0]  rxd_sync_q;
  logic [1:0]  txd_sync_q;
  rx_state_t   rx_state_q;
  logic [15:0] rx_cnt_q;
  logic [2:0]  rx_bit_q;
  logic [7:0]  rx_shift_q;
  logic        char_q;
  logic [15:0] quiet_cnt_q;
  logic        active_q;
  logic        quiet_evt;

  logic        wr_c1, wr_c2, wr_c3, wr_dat, rd_st, rd_dat;
  logic        tx_on, rx_on, standby, brk_bit;
  logic        loop_on, single_wire;
  logic        tx_on_rise, brk_rise;
  logic        tc;
  logic [7:0]  status;
  logic        ser_busy, ser_done, ser_bit;
  logic        ser_start;
  frame_kind_t ser_kind;
  logic        rx_line;
  logic        deliver;
  logic        wake_evt;

  assign wr_c1  = reg_wr && hit(reg_addr, `OFF_CTRL1);
  assign wr_c2  = reg_wr && hit(reg_addr, `OFF_CTRL2);
  assign wr_c3  = reg_wr && hit(reg_addr, `OFF_CTRL3);
  assign wr_dat = reg_wr && hit(reg_addr, `OFF_DATA);
  assign rd_st  = reg_rd && hit(reg_addr, `OFF_STAT1);
  assign rd_dat = reg_rd && hit(reg_addr, `OFF_DATA);

  assign tx_on       = ctrl2_q[`C2_TX_ON];
  assign rx_on       = ctrl2_q[`C2_RX_ON];
  assign standby     = ctrl2_q[`C2_STANDBY];
  assign brk_bit     = ctrl2_q[`C2_BREAK];
  assign loop_on     = ctrl1_q[`C1_LOOPBACK];
  assign single_wire = loop_on && ctrl1_q[`C1_RX_SOURCE];

  assign tx_on_rise = wr_c2 && reg_wdata[`C2_TX_ON] && !tx_on;
  assign brk_rise   = wr_c2 && reg_wdata[`C2_BREAK] && !brk_bit;

  // ********************************
  // Control registers
  // ********************************
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl1_q <= `CTRL_RESET;
      ctrl3_q <= `CTRL_RESET;
    end else begin
      if (wr_c1) begin
        ctrl1_q <= reg_wdata;
      end
      if (wr_c3) begin
        ctrl3_q <= reg_wdata;
      end
    end
  end

  // A software write of standby beats a wakeup in the same cycle
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl2_q <= `CTRL_RESET;
    end else if (wr_c2) begin
      ctrl2_q <= reg_wdata;
    end else if (wake_evt) begin
      ctrl2_q[`C2_STANDBY] <= 1'b0;
    end
  end

  // ********************************
  // Pin synchronisers
  // ********************************
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rxd_sync_q <= 2'h3;
      txd_sync_q <= 2'h3;
    end else begin
      rxd_sync_q <= {rxd_sync_q[0], rx_pin_in};
      txd_sync_q <= {txd_sync_q[0], tx_pin_in};
    end
  end

  // ********************************
  // Transmit queue
  // ********************************
  // Preamble first, then break, then data
  always_comb begin
    ser_start = 1'b0;
    ser_kind  = FRAME_DATA;
    if (!ser_busy && (tx_on || owned_q)) begin
      if (idle_pend_q) begin
        ser_start = 1'b1;
        ser_kind  = FRAME_IDLE;
      end else if (brk_pend_q) begin
        ser_start = 1'b1;
        ser_kind  = FRAME_BREAK;
      end else if (!tx_buffer_empty_flag_q) begin
        ser_start = 1'b1;
        ser_kind  = FRAME_DATA;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      idle_pend_q <= 1'b0;
    end else if (tx_on_rise) begin
      idle_pend_q <= 1'b1;
    end else if (ser_start && ser_kind == FRAME_IDLE) begin
      idle_pend_q <= 1'b0;
    end
  end

  // Finishing any character while the bit and transmitter enable are high queues a break;
  // a set that lands between two breaks can yield a second one
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      brk_pend_q <= 1'b0;
    end else if (brk_rise) begin
      brk_pend_q <= 1'b1;
    end else if (ser_done && brk_bit && tx_on) begin
      brk_pend_q <= 1'b1;
    end else if (ser_start && ser_kind == FRAME_BREAK) begin
      brk_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      owned_q <= 1'b0;
    end else if (tx_on) begin
      owned_q <= 1'b1;
    end else if (!ser_busy && !ser_start && !idle_pend_q
                 && !brk_pend_q) begin
      owned_q <= 1'b0;
    end
  end

  tx_serializer #(
    .BIT_CLKS   (BIT_CLKS)
  ) u_shifter (
    .core_clk   (core_clk),
    .nrst       (nrst),
    .start      (ser_start),
    .kind       (ser_kind),
    .data       (tx_buf_q),
    .long_break (ctrl3_q[`C3_LONG_BREAK]),
    .busy       (ser_busy),
    .done       (ser_done),
    .tx_bit     (ser_bit)
  );

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tx_buf_q <= 8'h00;
    end else if (wr_dat) begin
      tx_buf_q <= reg_wdata;
    end
  end

  // Moving the buffer into the shifter sets the flag and wins
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tx_buffer_empty_flag_q <= 1'b1;
    end else if (ser_start && ser_kind == FRAME_DATA) begin
      tx_buffer_empty_flag_q <= 1'b1;
    end else if (wr_dat && arm_q[4]) begin
      tx_buffer_empty_flag_q <= 1'b0;
    end
  end

  // Falls when a data write, preamble or break starts activity
  assign tc = tx_buffer_empty_flag_q && !ser_busy && !idle_pend_q
              && !brk_pend_q;

  // ********************************
  // Pin ownership
  // ********************************
  assign tx_pin_owned = owned_q;
  assign tx_pin_out   = ser_bit;
  assign tx_pin_oe    = owned_q && (!single_wire
                        || ctrl3_q[`C3_LINE_DIR]);
  assign rx_pin_owned = rx_on && !loop_on;

  always_comb begin
    if (!loop_on) begin
      rx_line = rxd_sync_q[1];
    end else if (single_wire) begin
      rx_line = txd_sync_q[1];
    end else begin
      rx_line = ser_bit;
    end
  end

  // ********************************
  // Receiver
  // ********************************
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rx_state_q <= RX_WAIT;
      rx_cnt_q   <= 16'h0000;
      rx_bit_q   <= 3'h0;
      rx_shift_q <= 8'h00;
      char_q     <= 1'b0;
    end else begin
      char_q <= 1'b0;
      if (!rx_on) begin
        rx_state_q <= RX_WAIT;
      end else begin
        unique case (rx_state_q)
          RX_WAIT: begin
            rx_cnt_q <= 16'h0000;
            if (!rx_line) begin
              rx_state_q <= RX_START;
            end
          end
          RX_START: begin
            if (rx_cnt_q == 16'(HALF_CLKS - 1)) begin
              rx_cnt_q   <= 16'h0000;
              rx_bit_q   <= 3'h0;
              rx_state_q <= rx_line ? RX_WAIT : RX_DATA;
            end else begin
              rx_cnt_q <= rx_cnt_q + 16'h0001;
            end
          end
          RX_DATA: begin
            if (rx_cnt_q == 16'(BIT_CLKS - 1)) begin
              rx_cnt_q   <= 16'h0000;
              rx_shift_q <= {rx_line, rx_shift_q[7:1]};
              rx_bit_q   <= rx_bit_q + 3'h1;
              if (rx_bit_q == 3'h7) begin
                rx_state_q <= RX_STOP;
              end
            end else begin
              rx_cnt_q <= rx_cnt_q + 16'h0001;
            end
          end
          RX_STOP: begin
            if (rx_cnt_q == 16'(BIT_CLKS - 1)) begin
              rx_state_q <= RX_WAIT;
              char_q     <= 1'b1;
            end else begin
              rx_cnt_q <= rx_cnt_q + 16'h0001;
            end
          end
        endcase
      end
    end
  end

  // Quiet line: a full character of high level after activity
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      quiet_cnt_q <= 16'h0000;
      active_q    <= 1'b0;
    end else begin
      if (!rx_on || !rx_line || rx_state_q != RX_WAIT) begin
        quiet_cnt_q <= 16'h0000;
      end else if (quiet_cnt_q != 16'(IDLE_CLKS - 1)) begin
        quiet_cnt_q <= quiet_cnt_q + 16'h0001;
      end
      if (char_q) begin
        active_q <= 1'b1;
      end else if (quiet_evt) begin
        active_q <= 1'b0;
      end
    end
  end

  assign quiet_evt = active_q
                     && quiet_cnt_q == 16'(IDLE_CLKS - 1);

  // In standby only a waking address mark reaches the buffer
  assign wake_evt = standby && (ctrl1_q[`C1_WAKE_SEL]
                    ? (char_q && rx_shift_q[7])
                    : quiet_evt);
  assign deliver  = char_q && (!standby || wake_evt);

  // ********************************
  // Receive flags
  // ********************************
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rx_data_q <= 8'h00;
      rx_buffer_full_flag_q    <= 1'b0;
      ovr_q     <= 1'b0;
    end else begin
      if (deliver && !rx_buffer_full_flag_q) begin
        rx_data_q <= rx_shift_q;
        rx_buffer_full_flag_q    <= 1'b1;
      end else if (rd_dat && arm_q[2]) begin
        rx_buffer_full_flag_q <= 1'b0;
      end
      if (deliver && rx_buffer_full_flag_q) begin
        ovr_q <= 1'b1;
      end else if (rd_dat && arm_q[0]) begin
        ovr_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      quiet_q <= 1'b0;
    end else if (quiet_evt && !standby) begin
      quiet_q <= 1'b1;
    end else if (rd_dat && arm_q[1]) begin
      quiet_q <= 1'b0;
    end
  end

  // ********************************
  // Status, clear arming and read port
  // ********************************
  assign status = {tx_buffer_empty_flag_q, tc, rx_buffer_full_flag_q, quiet_q, ovr_q, 3'h0};

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      arm_q <= 5'h00;
    end else if (rd_st) begin
      arm_q <= {status[`S1_TX_EMPTY], status[`S1_TX_DONE],
                status[`S1_RX_FULL], status[`S1_QUIET],
                status[`S1_OVERRUN]};
    end else if (wr_dat || rd_dat) begin
      arm_q <= 5'h00;
    end
  end

  // Status writes decode to nothing, so no state is touched
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `OFF_CTRL1: reg_rdata <= ctrl1_q;
        `OFF_CTRL2: reg_rdata <= ctrl2_q;
        `OFF_STAT1: reg_rdata <= status;
        `OFF_CTRL3: reg_rdata <= ctrl3_q;
        `OFF_DATA:  reg_rdata <= rx_data_q;
        default:    reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ********************************
  // Interrupt request
  // ********************************
  assign irq_req =
    (tx_buffer_empty_flag_q  && ctrl2_q[`C2_TX_EMPTY_IE])
    || (tc      && ctrl2_q[`C2_TX_DONE_IE])
    || (rx_buffer_full_flag_q  && ctrl2_q[`C2_RX_FULL_IE])
    || (quiet_q && ctrl2_q[`C2_QUIET_IE]);

endmodule // uart_control_and_status

// ===== verification/uart_cs_assertions.sv
// Assertion checker for the serial control and status block
`timescale 1ns/10ps
`include "uart_cfg.svh"
module uart_cs_checker #(
  parameter int unsigned BIT_CLKS = 16
) (
  input wire logic       core_clk,
  input wire logic       nrst,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       tx_pin_in,
  input wire logic       tx_pin_out,
  input wire logic       tx_pin_oe,
  input wire logic       rx_pin_in,
  input wire logic       rx_pin_owned,
  input wire logic       tx_pin_owned,
  input wire logic       irq_req
);
  logic [7:0] c2_q;
  logic [2:0] mode_q;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // ********
  // Shadow of written control bits; standby bit self-clears, not used
  // ********
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      c2_q <= 8'h00;
    end else if (reg_wr && reg_addr == `OFF_CTRL2) begin
      c2_q <= reg_wdata;
    end
  end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mode_q <= 3'h0;
    end else if (reg_wr && reg_addr == `OFF_CTRL1) begin
      mode_q[2:1] <= {reg_wdata[`C1_LOOPBACK], reg_wdata[`C1_RX_SOURCE]};
    end else if (reg_wr && reg_addr == `OFF_CTRL3) begin
      mode_q[0] <= reg_wdata[`C3_LINE_DIR];
    end
  end
  // ********
  // Properties
  // ********
  a_irq_masked: assert property (c2_q[7:4] == 4'h0 |-> !irq_req)
    else $error("interrupt with all enables clear");
  a_irq_per_flag: assert property (
    reg_rd && reg_addr == `OFF_STAT1 |=>
    $past(irq_req) == |(reg_rdata[7:4] & c2_q[7:4]))
    else $error("interrupt does not match flags and enables");
  a_ctrl_readback: assert property (
    reg_rd && reg_addr == `OFF_CTRL2 |=>
    {reg_rdata[7:2], reg_rdata[0]} == {c2_q[7:2], c2_q[0]})
    else $error("control read differs from last write");
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data without read strobe");
  a_rx_owned: assert property (
    rx_pin_owned == (c2_q[2] && !mode_q[2]))
    else $error("receive pin ownership wrong");
  a_tx_owned: assert property (
    c2_q[3] && $past(c2_q[3]) |-> tx_pin_owned)
    else $error("transmit pin not owned while enabled");
  a_oe_single: assert property (
    mode_q[2] && mode_q[1] |-> tx_pin_oe == (tx_pin_owned && mode_q[0]))
    else $error("single-wire direction wrong");
  a_oe_normal: assert property (
    !(mode_q[2] && mode_q[1]) |-> tx_pin_oe == tx_pin_owned)
    else $error("transmit pin drive wrong");
  // A falling edge opens a zero bit; the rise ending a frame may be last
  a_hold_pin: assert property (
    $fell(tx_pin_out) |-> tx_pin_owned [*3])
    else $error("pin released inside a bit");
  a_release_off: assert property (
    $fell(tx_pin_owned) |-> !$past(c2_q[3]))
    else $error("pin released while enabled");
endmodule // uart_cs_checker
bind uart_control_and_status uart_cs_checker #(.BIT_CLKS(BIT_CLKS)) u_chk (
  .core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .tx_pin_in(tx_pin_in), .tx_pin_out(tx_pin_out),
  .tx_pin_oe(tx_pin_oe), .rx_pin_in(rx_pin_in),
  .rx_pin_owned(rx_pin_owned), .tx_pin_owned(tx_pin_owned),
  .irq_req(irq_req));

// ===== verification/uart_far_end.sv
// Far-end serial transceiver model
`timescale 1ns/10ps
module uart_far_end #(
  parameter int unsigned BIT_CLKS = 16
) (
  input  wire logic core_clk,
  input  wire logic line_in,
  output logic      line_out
);
  logic [7:0] got_byte;
  logic [7:0] sh;
  int         got_cnt = 0;
  initial line_out = 1'b1;
  // ********
  // Sender: start, LSB first, stop; line idles high
  // ********
  task automatic send(input logic [7:0] b);
    for (int i = -1; i < 9; i++) begin
      @(posedge core_clk);
      line_out <= (i < 0) ? 1'b0 : (i > 7) ? 1'b1 : b[i[2:0]];
      repeat (BIT_CLKS - 1) @(posedge core_clk);
    end
  endtask
  // ********
  // Receiver: mid-bit sampling; a break reads as a zero byte
  // ********
  always begin
    @(negedge line_in);
    repeat (BIT_CLKS / 2) @(posedge core_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CLKS) @(posedge core_clk);
      sh[i] = line_in;
    end
    repeat (BIT_CLKS) @(posedge core_clk);
    got_byte = sh;
    got_cnt++;
  end
endmodule // uart_far_end

// ===== verification/tb_uart_control_and_status.sv
// Testbench for the serial control and status block
`timescale 1ns/10ps
`include "uart_cfg.svh"
module tb_uart_control_and_status;
  localparam int unsigned BC = 4;
  logic       core_clk, nrst, reg_wr, reg_rd;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, v;
  logic       tx_pin_out, tx_pin_oe, rx_pin_in;
  logic       rx_pin_owned, tx_pin_owned, irq_req;
  wire        tx_pin_in;
  int         fail_count = 0;
  int         num_checks = 0;
  int         i, k, len;
  // Released transmit pin is pulled high
  assign tx_pin_in = tx_pin_oe ? tx_pin_out : 1'b1;
  uart_control_and_status #(.BIT_CLKS(BC)) uut (
    .core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .tx_pin_in(tx_pin_in), .tx_pin_out(tx_pin_out),
    .tx_pin_oe(tx_pin_oe), .rx_pin_in(rx_pin_in),
    .rx_pin_owned(rx_pin_owned), .tx_pin_owned(tx_pin_owned),
    .irq_req(irq_req));
  uart_far_end #(.BIT_CLKS(BC)) far (
    .core_clk(core_clk), .line_in(tx_pin_in), .line_out(rx_pin_in));
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // ********
  // Bus tasks and checks
  // ********
  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic give_up(input int n);
    if (n >= 3000) begin
      fail_count++;
      $display("wrong value at %0t: wait ran out", $time);
      close_out();
    end
  endtask
  task automatic tick;
    @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic rdc(input logic [2:0] a, input logic [7:0] e);
    rd(a, v);
    check8(v, e);
  endtask
  task automatic wait_free;
    for (k = 0; k < 3000 && tx_pin_owned; k++) tick();
    give_up(k);
  endtask
  // ********
  // Scenarios
  // ********
  initial begin
    nrst = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    rdc(`OFF_CTRL2, 8'h00);
    rdc(`OFF_STAT1, 8'hC0);
    rdc(3'h5, 8'h00);
    // Only the two transmit flags are set now
    for (i = 0; i < 4; i++) begin
      wr(`OFF_CTRL2, 8'h80 >> i);
      check8({7'h0, irq_req}, {7'h0, i < 2});
      rdc(`OFF_CTRL2, 8'h80 >> i);
    end
    wr(`OFF_STAT1, 8'hFF);
    wr(`OFF_STAT1, 8'h00);
    rdc(`OFF_STAT1, 8'hC0);
    rdc(`OFF_CTRL2, 8'h10);
    wr(`OFF_CTRL2, 8'h08);
    rd(`OFF_STAT1, v);
    wr(`OFF_DATA, 8'hA5);
    rdc(`OFF_STAT1, 8'h00);
    wr(`OFF_CTRL2, 8'h00);
    check8({7'h0, tx_pin_owned}, 8'h01);
    for (k = 0; k < 3000 && far.got_cnt < 1; k++) tick();
    give_up(k);
    check8(far.got_byte, 8'hA5);
    wait_free();
    for (i = 0; i < 2; i++) begin
      wr(`OFF_CTRL3, i ? 8'h80 : 8'h00);
      wr(`OFF_CTRL2, 8'h08);
      wr(`OFF_CTRL2, 8'h09);
      wr(`OFF_CTRL2, 8'h08);
      for (k = 0; k < 3000 && tx_pin_in !== 1'b0; k++) tick();
      give_up(k);
      for (len = 0; len < 100 && tx_pin_in === 1'b0; len++) tick();
      check8(8'(len), 8'(BC * (i ? 13 : 10)));
      wr(`OFF_CTRL2, 8'h00);
      wait_free();
    end
    // Enable queues a preamble; a held break bit keeps queuing breaks
    wr(`OFF_CTRL2, 8'h08);
    rdc(`OFF_STAT1, 8'h80);
    wr(`OFF_CTRL2, 8'h09);
    for (i = 0; i < 2; i++) begin
      for (k = 0; k < 3000 && tx_pin_in !== 1'b0; k++) tick();
      give_up(k);
      for (len = 0; len < 100 && tx_pin_in === 1'b0; len++) tick();
      check8(8'(len), 8'(BC * 13));
    end
    wr(`OFF_CTRL2, 8'h00);
    wait_free();
    wr(`OFF_CTRL2, 8'h04);
    check8({7'h0, rx_pin_owned}, 8'h01);
    far.send(8'h3C);
    for (k = 0; k < 3000 && v[5] !== 1'b1; k++) rd(`OFF_STAT1, v);
    give_up(k);
    rdc(`OFF_DATA, 8'h3C);
    rd(`OFF_STAT1, v);
    check8(v & 8'h20, 8'h00);
    wr(`OFF_CTRL1, 8'h80);
    check8({7'h0, rx_pin_owned}, 8'h00);
    wr(`OFF_CTRL1, 8'hA0);
    wr(`OFF_CTRL3, 8'h20);
    wr(`OFF_CTRL2, 8'h08);
    tick();
    check8({7'h0, tx_pin_oe}, 8'h01);
    wr(`OFF_CTRL3, 8'h00);
    check8({7'h0, tx_pin_oe}, 8'h00);
    wr(`OFF_CTRL2, 8'h00);
    wait_free();
    // Address-mark wake: top bit clear is ignored, top bit set wakes
    wr(`OFF_CTRL1, 8'h08);
    wr(`OFF_CTRL2, 8'h06);
    far.send(8'h12);
    repeat (8) tick();
    rdc(`OFF_CTRL2, 8'h06);
    far.send(8'h81);
    repeat (8) tick();
    rdc(`OFF_CTRL2, 8'h04);
    // Idle-line wake: standby holds through a character, ends on quiet
    wr(`OFF_CTRL1, 8'h00);
    wr(`OFF_CTRL2, 8'h06);
    far.send(8'h55);
    rdc(`OFF_CTRL2, 8'h06);
    repeat (60) tick();
    rdc(`OFF_CTRL2, 8'h04);
    close_out();
  end
endmodule // tb_uart_control_and_status
